/* File: verilog/interval_timers_defines.vh */
`ifndef INTERVAL_TIMERS_DEFINES_VH
`define INTERVAL_TIMERS_DEFINES_VH
// ==========================================================
// Register addresses
`define ADDR_TIMER_B_CONTROL    8'hBA
`define ADDR_TIMER_A_CONTROL    8'hBB
`define ADDR_TIMER_A_REFERENCE  8'hBC
`define ADDR_TIMER_B_REFERENCE  8'hBD
`define ADDR_TIMER_A_COUNTER    8'hBE
`define ADDR_TIMER_B_COUNTER    8'hBF
`define ADDR_PENDING_SECOND     8'hC0
// ==========================================================
// Reset values
`define CONTROL_RESET           8'h00
`define REFERENCE_RESET         8'hFF
// ==========================================================
// Control field positions
`define BIT_JOIN16              7
`define BIT_SEL_HI              6
`define BIT_SEL_LO              4
`define BIT_CLEAR               3
`define BIT_RUN                 2
`define BIT_IRQ_EN              1
// ==========================================================
// Clock select codes
`define SEL_DIV512              3'h0
`define SEL_DIV256              3'h1
`define SEL_DIV64               3'h2
`define SEL_DIV8                3'h3
`define SEL_DIV1                3'h4
`define SEL_SUB                 3'h5
`define SEL_EXT                 3'h6
// ==========================================================
// Prescaler
`define PRESCALE_WIDTH          9
`endif

/* File: verilog/timer_tick_select.v */
`include "interval_timers_defines.vh"

module timer_tick_select #(
   parameter HAS_EXT = 1
) (
   input  wire                       i_clk,
   input  wire                       i_nrst,
   input  wire [`PRESCALE_WIDTH-1:0] i_prescale,
   input  wire [`PRESCALE_WIDTH-1:0] i_prescale_next,
   input  wire                       i_sub_tick,
   input  wire                       i_ext_tick,
   input  wire [2:0]                 i_sel,
   output reg                        o_tick
);
   // ==========================================================
   // Divider tap rises, one pulse per period
   function rise;
      input [`PRESCALE_WIDTH-1:0] cur;
      input [`PRESCALE_WIDTH-1:0] nxt;
      input [3:0]                 b;
      begin
         rise = ~cur[b] & nxt[b];
      end
   endfunction

   reg tick_next;

   always @* begin
      case (i_sel)
         `SEL_DIV512: tick_next = (i_prescale == 9'h1FF);
         `SEL_DIV256: tick_next = rise(i_prescale, i_prescale_next, 4'h7);
         `SEL_DIV64:  tick_next = rise(i_prescale, i_prescale_next, 4'h5);
         `SEL_DIV8:   tick_next = rise(i_prescale, i_prescale_next, 4'h2);
         `SEL_DIV1:   tick_next = 1'b1;
         `SEL_SUB:    tick_next = i_sub_tick;
         `SEL_EXT:    tick_next = (HAS_EXT != 0) ? i_ext_tick : 1'b0;
         default:     tick_next = 1'b0;
      endcase
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tick <= 1'b0;
      end else begin
         o_tick <= tick_next;
      end
   end
endmodule

/* File: verilog/dual_interval_timers.v */
`include "interval_timers_defines.vh"

// What this block does
// - Timer A clock: five dividers, sub, external
// - Each: 8-bit counter, comparator, reference register
// - Timer A drives a match output pin
// - Controls at BBH (A) and BAH (B)
// - Timer A control resets to 00H
// - Timer B control resets to 00H
// - Writing one to bit 3 clears counter; B's bit 3 ignored when joined
// - Timer B bit 2 enables counting when not joined
// - Timer B bit 1 enables match interrupt
// - Match raises signal, clears counter, resumes
// - Matches set pending bits; write zero clears
// - Pending sets even with interrupt disabled
// - Timer A bit 7 joins into 16 bits
module dual_interval_timers (
   input  wire       i_clk,
   input  wire       i_nrst,
   input  wire [7:0] i_addr,
   input  wire       i_wr,
   input  wire       i_rd,
   input  wire [7:0] i_wdata,
   input  wire       i_sub_clk,
   input  wire       i_external_timer_clock,
   output reg  [7:0] o_rdata,
   output reg        o_timer_a_match_output,
   output reg        o_timer_a_match_irq,
   output reg        o_timer_b_match_irq
);
   // ==========================================================
   // Registers
   reg  [7:0] timer_a_control_reg;
   reg  [7:0] timer_b_control_reg;
   reg  [7:0] timer_a_reference_reg;
   reg  [7:0] timer_b_reference_reg;
   reg  [7:0] timer_a_counter_reg;
   reg  [7:0] timer_b_counter_reg;
   reg  [1:0] pending_reg;
   reg  [`PRESCALE_WIDTH-1:0] prescale_reg;
   reg  [1:0] sub_sync_reg;
   reg        sub_prev_reg;
   reg  [1:0] ext_sync_reg;
   reg        ext_prev_reg;

   wire [`PRESCALE_WIDTH-1:0] prescale_next = prescale_reg + 9'h001;
   wire       wr_a_ctl = i_wr & (i_addr == `ADDR_TIMER_A_CONTROL);
   wire       wr_b_ctl = i_wr & (i_addr == `ADDR_TIMER_B_CONTROL);
   wire       wr_pnd   = i_wr & (i_addr == `ADDR_PENDING_SECOND);
   wire       clear_a  = wr_a_ctl & i_wdata[`BIT_CLEAR];
   wire       clear_b  = wr_b_ctl & i_wdata[`BIT_CLEAR];
   wire       joined   = timer_a_control_reg[`BIT_JOIN16];
   wire       run_a    = timer_a_control_reg[`BIT_RUN];
   wire       run_b    = joined ? run_a : timer_b_control_reg[`BIT_RUN];
   wire [2:0] sel_a    = timer_a_control_reg[`BIT_SEL_HI:`BIT_SEL_LO];
   wire [2:0] sel_b    = joined ? sel_a
                                : timer_b_control_reg[`BIT_SEL_HI:`BIT_SEL_LO];
   wire       tick_a;
   wire       tick_b_own;

   // ==========================================================
   // Edge detect of sub and external clocks after synchronisers
   wire sub_tick = sub_sync_reg[1] & ~sub_prev_reg;
   wire ext_tick = ext_sync_reg[1] & ~ext_prev_reg;

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prescale_reg <= 9'h000;
         sub_sync_reg <= 2'h0;
         sub_prev_reg <= 1'b0;
         ext_sync_reg <= 2'h0;
         ext_prev_reg <= 1'b0;
      end else begin
         prescale_reg <= prescale_next;
         sub_sync_reg <= {sub_sync_reg[0], i_sub_clk};
         sub_prev_reg <= sub_sync_reg[1];
         ext_sync_reg <= {ext_sync_reg[0], i_external_timer_clock};
         ext_prev_reg <= ext_sync_reg[1];
      end
   end

   timer_tick_select #(.HAS_EXT(1)) u_tick_a (
      .i_clk           (i_clk),
      .i_nrst          (i_nrst),
      .i_prescale      (prescale_reg),
      .i_prescale_next (prescale_next),
      .i_sub_tick      (sub_tick),
      .i_ext_tick      (ext_tick),
      .i_sel           (sel_a),
      .o_tick          (tick_a)
   );

   timer_tick_select #(.HAS_EXT(0)) u_tick_b (
      .i_clk           (i_clk),
      .i_nrst          (i_nrst),
      .i_prescale      (prescale_reg),
      .i_prescale_next (prescale_next),
      .i_sub_tick      (sub_tick),
      .i_ext_tick      (ext_tick),
      .i_sel           (sel_b),
      .o_tick          (tick_b_own)
   );

   // ==========================================================
   // Comparators
   wire match_a_8  = (timer_a_counter_reg == timer_a_reference_reg);
   wire match_b_8  = (timer_b_counter_reg == timer_b_reference_reg);
   // Joined mode: A is high byte, B low byte
   wire match_16   = match_a_8 & match_b_8;
   wire ev_a       = joined ? (run_a & tick_a & match_16) : (run_a & tick_a & match_a_8);
   wire ev_b       = joined ? 1'b0 : (run_b & tick_b_own & match_b_8);
   wire b_carry    = joined & run_a & tick_a & (timer_b_counter_reg == 8'hFF);

   // ==========================================================
   // Counters
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         timer_a_counter_reg <= 8'h00;
         timer_b_counter_reg <= 8'h00;
      end else begin
         if (joined) begin
            if (clear_a || ev_a) begin
               timer_a_counter_reg <= 8'h00;
               timer_b_counter_reg <= 8'h00;
            end else if (run_a && tick_a) begin
               timer_b_counter_reg <= timer_b_counter_reg + 8'h01;
               if (b_carry) begin
                  timer_a_counter_reg <= timer_a_counter_reg + 8'h01;
               end
            end
         end else begin
            if (clear_a || ev_a) begin
               timer_a_counter_reg <= 8'h00;
            end else if (run_a && tick_a) begin
               timer_a_counter_reg <= timer_a_counter_reg + 8'h01;
            end
            if (clear_b || ev_b) begin
               timer_b_counter_reg <= 8'h00;
            end else if (run_b && tick_b_own) begin
               timer_b_counter_reg <= timer_b_counter_reg + 8'h01;
            end
         end
      end
   end

   // ==========================================================
   // Software registers; clear bit is a strobe, not stored
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         timer_a_control_reg   <= `CONTROL_RESET;
         timer_b_control_reg   <= `CONTROL_RESET;
         timer_a_reference_reg <= `REFERENCE_RESET;
         timer_b_reference_reg <= `REFERENCE_RESET;
      end else begin
         if (wr_a_ctl) begin
            timer_a_control_reg <= i_wdata & 8'hF7;
         end
         if (wr_b_ctl) begin
            timer_b_control_reg <= i_wdata & 8'h76;
         end
         if (i_wr && i_addr == `ADDR_TIMER_A_REFERENCE) begin
            timer_a_reference_reg <= i_wdata;
         end
         if (i_wr && i_addr == `ADDR_TIMER_B_REFERENCE) begin
            timer_b_reference_reg <= i_wdata;
         end
      end
   end

   // ==========================================================
   // Pending bits; a match in the clearing cycle wins
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pending_reg <= 2'h0;
      end else begin
         pending_reg[0] <= ev_a | (pending_reg[0] & ~(wr_pnd & ~i_wdata[0]));
         pending_reg[1] <= ev_b | (pending_reg[1] & ~(wr_pnd & ~i_wdata[1]));
      end
   end

   // ==========================================================
   // Outputs
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_timer_a_match_output <= 1'b0;
         o_timer_a_match_irq    <= 1'b0;
         o_timer_b_match_irq    <= 1'b0;
      end else begin
         o_timer_a_match_output <= ev_a;
         o_timer_a_match_irq    <= ev_a & timer_a_control_reg[`BIT_IRQ_EN];
         o_timer_b_match_irq    <= ev_b & timer_b_control_reg[`BIT_IRQ_EN];
      end
   end

   // ==========================================================
   // Read port, registered; unmapped reads zero
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `ADDR_TIMER_A_CONTROL:   o_rdata <= timer_a_control_reg;
            `ADDR_TIMER_B_CONTROL:   o_rdata <= timer_b_control_reg;
            `ADDR_TIMER_A_REFERENCE: o_rdata <= timer_a_reference_reg;
            `ADDR_TIMER_B_REFERENCE: o_rdata <= timer_b_reference_reg;
            `ADDR_TIMER_A_COUNTER:   o_rdata <= timer_a_counter_reg;
            `ADDR_TIMER_B_COUNTER:   o_rdata <= timer_b_counter_reg;
            `ADDR_PENDING_SECOND:    o_rdata <= {6'h00, pending_reg};
            default:                 o_rdata <= 8'h00;
         endcase
      end
   end
endmodule

/* File: verification/dual_interval_timers_checker.sv */
// ==========================================================
// Port-level checks
module dual_interval_timers_checker (
   input wire       i_clk,
   input wire       i_nrst,
   input wire [7:0] i_addr,
   input wire       i_wr,
   input wire       i_rd,
   input wire [7:0] i_wdata,
   input wire [7:0] o_rdata,
   input wire       o_timer_a_match_output,
   input wire       o_timer_a_match_irq,
   input wire       o_timer_b_match_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   reg a_en_reg;
   reg b_en_reg;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   // ==========================================================
   // Interrupt enables as last written
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         a_en_reg <= 1'b0;
         b_en_reg <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == 8'hBB) a_en_reg <= i_wdata[1];
         if (i_addr == 8'hBA) b_en_reg <= i_wdata[1];
      end
   end
   sequence wr_rd_s(ad);
      i_wr && i_addr == ad ##1 i_rd && !i_wr && i_addr == ad;
   endsequence
   // ==========================================================
   // Assertions
   ctl_a_readback_a : assert property (
      wr_rd_s(8'hBB) |=> o_rdata == ($past(i_wdata, 2) & 8'hF7))
      else $error("timer A control readback wrong");
   ctl_b_readback_a : assert property (
      wr_rd_s(8'hBA) |=> o_rdata == ($past(i_wdata, 2) & 8'h76))
      else $error("timer B control readback wrong");
   unmapped_zero_a : assert property (
      i_rd && !i_wr && i_addr == 8'h00 |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   reset_quiet_a : assert property (
      $rose(i_nrst) |-> !(o_timer_a_match_output || o_timer_a_match_irq || o_timer_b_match_irq))
      else $error("event output right after reset");
   irq_a_enable_a : assert property (
      o_timer_a_match_irq |-> $past(a_en_reg) || $past(a_en_reg, 2))
      else $error("timer A irq while disabled");
   irq_b_enable_a : assert property (
      o_timer_b_match_irq |-> $past(b_en_reg) || $past(b_en_reg, 2))
      else $error("timer B irq while disabled");
   irq_has_match_a : assert property (
      o_timer_a_match_irq |-> o_timer_a_match_output)
      else $error("timer A irq without match output");
   pend_on_match_a : assert property (
      o_timer_a_match_output && i_rd && !i_wr && i_addr == 8'hC0 |=> o_rdata[0])
      else $error("pending bit missing after match");
endmodule

bind dual_interval_timers dual_interval_timers_checker u_dual_interval_timers_checker (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
   .i_wdata(i_wdata), .o_rdata(o_rdata), .o_timer_a_match_output(o_timer_a_match_output),
   .o_timer_a_match_irq(o_timer_a_match_irq), .o_timer_b_match_irq(o_timer_b_match_irq));

/* File: verification/dual_interval_timers_tb.sv */
module dual_interval_timers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_sub_clk = 1'b0;
   logic        i_external_timer_clock = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [7:0]  i_wdata = 8'h00;
   wire  [7:0]  o_rdata;
   wire         o_timer_a_match_output;
   wire         o_timer_a_match_irq;
   wire         o_timer_b_match_irq;
   logic [15:0] q[$];
   logic        rd_d = 1'b0;
   int failures = 0, samples_checked = 0, seed = 32'hEECC7DC2;
   int gap_a = 0, gap_b = 0, last_a = 0, last_b = 0, cnt_a = 0, cnt_b = 0, irq_a = 0;
   int ds = 0, de = 0, k, s, n;
   int per[7] = '{512, 256, 64, 8, 1, 12, 10};
   dual_interval_timers u_dual_interval_timers (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_sub_clk(i_sub_clk),
      .i_external_timer_clock(i_external_timer_clock), .o_rdata(o_rdata),
      .o_timer_a_match_output(o_timer_a_match_output),
      .o_timer_a_match_irq(o_timer_a_match_irq), .o_timer_b_match_irq(o_timer_b_match_irq));
   always #5 i_clk = ~i_clk;
   // ==========================================================
   // Slow clocks: sub 12 cycles, external 10, so a swap shows
   always @(negedge i_clk) begin
      ds <= (ds == 5) ? 0 : ds + 1;
      de <= (de == 4) ? 0 : de + 1;
      if (ds == 5) i_sub_clk <= ~i_sub_clk;
      if (de == 4) i_external_timer_clock <= ~i_external_timer_clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // ==========================================================
   // Output watcher: read results and event spacing
   always @(posedge i_clk) rd_d <= i_rd;
   always @(negedge i_clk) begin
      gap_a++;
      gap_b++;
      if (o_timer_a_match_output === 1'b1) begin
         last_a = gap_a;
         gap_a = 0;
         cnt_a++;
      end
      if (o_timer_b_match_irq === 1'b1) begin
         last_b = gap_b;
         gap_b = 0;
         cnt_b++;
      end
      if (o_timer_a_match_irq === 1'b1) irq_a++;
      if (rd_d === 1'b1 && q.size() == 0) check(32'h1, 32'h0);
      else if (rd_d === 1'b1) begin
         check(o_rdata & q[0][15:8], q[0][7:0] & q[0][15:8]);
         void'(q.pop_front());
      end
   end
   // ==========================================================
   // Bus tasks; each starts at a falling edge and holds its strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_rd = 1'b0;
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      i_wr = 1'b0;
      i_addr = a;
      i_rd = 1'b1;
      q.push_back({m, e});
      @(negedge i_clk);
   endtask
   task automatic idle();
      i_wr = 1'b0;
      i_rd = 1'b0;
      @(negedge i_clk);
   endtask
   // Interval between the first and second match after a clear
   task automatic measure(input logic b, input logic [7:0] c, input logic [7:0] r, input int p);
      int m;
      int t;
      wr(b ? 8'hBD : 8'hBC, r);
      wr(b ? 8'hBA : 8'hBB, c);
      idle();
      t = b ? cnt_b : cnt_a;
      for (m = 0; m < 9000 && (b ? cnt_b : cnt_a) < t + 2; m++) @(negedge i_clk);
      check(b ? last_b : last_a, p * (r + 1));
      wr(b ? 8'hBA : 8'hBB, 8'h00);
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #1000000;
      failures++;
      conclude();
   end
   initial begin
      repeat (12) @(negedge i_clk);
      i_nrst = 1'b1;
      for (k = 0; k < 7; k++) rd(8'hBA + 8'(k), (k == 2 || k == 3) ? 8'hFF : 8'h00, 8'hFF);
      rd(8'h00, 8'h00, 8'hFF);
      for (k = 0; k < 4; k++) begin
         s = $random(seed);
         wr(8'hBB, 8'(s));
         rd(8'hBB, 8'(s) & 8'hF7, 8'hFF);
         wr(8'hBA, 8'(s >> 8));
         rd(8'hBA, 8'(s >> 8) & 8'h76, 8'hFF);
      end
      wr(8'hBB, 8'h00);
      // Every clock code of A, then of B (no external option on B)
      for (k = 0; k < 13; k++)
         measure(k > 6, {1'b0, 3'(k % 7), 4'hE}, 8'(1 + ($random(seed) & 3)), per[k % 7]);
      // Joined mode: 16-bit reference 0x0002 gives three ticks
      s = cnt_b;
      wr(8'hBD, 8'h02);
      measure(1'b0, 8'hCE, 8'h00, 3);
      check(cnt_b, s);
      rd(8'hC0, 8'h03, 8'h03);
      wr(8'hC0, 8'h00);
      // Interrupt off: pending still rises and is polled
      s = irq_a;
      wr(8'hBC, 8'h20);
      wr(8'hBB, 8'h4C);
      n = 0;
      do begin
         rd(8'hC0, 8'h00, 8'h00);
         n++;
      end while (o_rdata[0] !== 1'b1 && n < 200);
      check(n < 200, 1'b1);
      check(irq_a, s);
      wr(8'hC0, 8'h00);
      rd(8'hC0, 8'h00, 8'h01);
      wr(8'hBB, 8'h00);
      idle();
      idle();
      conclude();
   end
endmodule
